// [inc/slp_regs.vh]
`ifndef SLP_REGS_VH
`define SLP_REGS_VH
// =====================================================
// structure
`define SLP_NUM_CH 4
`define SLP_CH_W 4
`define SLP_APS_W 13
// =====================================================
// register offsets (byte addresses)
`define SLP_CTRL_OFS 8'h00
`define SLP_WTR_OFS 8'h04
`define SLP_CMD_OFS 8'h08
`define SLP_STAT_OFS 8'h0c
`define SLP_APS_OFS 8'h10
// =====================================================
// control register fields
`define SLP_CTRL_BIDIR 0
`define SLP_CTRL_EXTRA 1
`define SLP_CTRL_NULL_LSB 2
`define SLP_CTRL_REPORT 4
`define SLP_CTRL_NCH_LSB 8
`define SLP_CTRL_RST 12'h010
// wait-to-restore period in seconds: reset value, then upper bound of the range
`define SLP_WTR_RST 10'h12c
`define SLP_WTR_MAX 10'h2d0
// =====================================================
// command register fields and codes
`define SLP_CMD_CH_LSB 4
`define SLP_CMD_NONE 3'h0
`define SLP_CMD_LOCKOUT 3'h1
`define SLP_CMD_FORCED 3'h2
`define SLP_CMD_MANUAL 3'h3
`define SLP_CMD_CLEAR 3'h4
`define SLP_CMD_EXERCISE_COMMAND 3'h5
// =====================================================
// request codes carried in the switching signalling, higher wins
`define SLP_REQ_LO 4'hf
`define SLP_REQ_FS 4'he
`define SLP_REQ_SF 4'hb
`define SLP_REQ_SD 4'h9
`define SLP_REQ_MS 4'h7
`define SLP_REQ_WTR 4'h6
`define SLP_REQ_EXERCISE_COMMAND 4'h4
`define SLP_REQ_RR 4'h2
`define SLP_REQ_NR 4'h0
// =====================================================
// null signal choices
`define SLP_NULL_COPY 2'h0
`define SLP_NULL_ONES 2'h1
`define SLP_NULL_TEST 2'h2
// =====================================================
// frame layout: byte positions after frame start, then frames needed to accept signalling
`define SLP_K1_POS 8'h01
`define SLP_K2_POS 8'h02
`define SLP_APS_PERSIST 2'h3
// =====================================================
// timing
`define SLP_CLK_HZ 40000000
`define SLP_WTR_UNIT_S 1
`define SLP_SEC_CYCLES (`SLP_CLK_HZ * `SLP_WTR_UNIT_S)
`endif

// [hw/slp_aps_extract.v]
`timescale 1ns/100ps
`include "slp_regs.vh"
// =====================================================
// switching signalling extraction with persistence check
module slp_aps_extract (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // incoming section stream
  input wire [7:0] d_in,
  input wire fs_in,
  // recovered stream and accepted signalling
  output reg [7:0] d_out,
  output reg fs_out,
  output reg [`SLP_APS_W-1:0] aps_out
);
  reg [7:0] pos_r; // byte position inside the frame
  reg [7:0] k1_r; // first switching byte of this frame
  reg [`SLP_APS_W-1:0] cand_r; // candidate value under test
  reg [1:0] cnt_r; // consecutive frames holding the candidate
  wire [7:0] pos_now; // position of the byte now present
  wire [`SLP_APS_W-1:0] sample; // this frame's 13 bits

  assign pos_now = fs_in ? 8'h00 : pos_r;
  assign sample = {k1_r, d_in[7:3]};

  // =====================================================
  // data recovery: one register stage, nothing altered
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      d_out <= 8'h00;
      fs_out <= 1'b0;
    end else begin
      d_out <= d_in;
      fs_out <= fs_in;
    end
  end

  // =====================================================
  // position counter restarts at each frame start, saturates on long frames
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pos_r <= 8'h00;
    end else if (pos_now != 8'hff) begin
      pos_r <= pos_now + 8'h01;
    end else begin
      pos_r <= 8'hff;
    end
  end

  // =====================================================
  // one sample per frame, adopted after three identical frames
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      k1_r <= 8'h00;
      cand_r <= {`SLP_APS_W{1'b0}};
      cnt_r <= 2'h0;
      aps_out <= {`SLP_APS_W{1'b0}};
    end else begin
      if (pos_now == `SLP_K1_POS) begin
        k1_r <= d_in;
      end
      if (pos_now == `SLP_K2_POS) begin
        // a single differing frame restarts the count, old value kept
        if (sample == cand_r) begin
          if (cnt_r != `SLP_APS_PERSIST) begin
            cnt_r <= cnt_r + 2'h1;
          end
          if (cnt_r == `SLP_APS_PERSIST - 2'h1) begin
            aps_out <= cand_r;
          end
        end else begin
          cand_r <= sample;
          cnt_r <= 2'h1;
        end
      end
    end
  end
endmodule

// [hw/slp_one_to_n_protection.v]
`timescale 1ns/100ps
`include "slp_regs.vh"
module slp_one_to_n_protection #(
  parameter SEC_CYCLES = `SLP_SEC_CYCLES
) (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire RESETN_IN,
  // apb slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // transmit side: normal and extra traffic inputs
  input wire [8*`SLP_NUM_CH-1:0] NORM_TX_DATA_IN,
  input wire NORM_TX_FS_IN,
  input wire [7:0] EXTRA_TX_DATA_IN,
  // transmit side: working and protection section outputs
  output reg [8*`SLP_NUM_CH-1:0] WORK_TX_DATA_OUT,
  output reg WORK_TX_FS_OUT,
  output reg [7:0] PROT_TX_DATA_OUT,
  output reg PROT_TX_FS_OUT,
  // receive side: working sections
  input wire [8*`SLP_NUM_CH-1:0] WORK_RX_DATA_IN,
  input wire WORK_RX_FS_IN,
  input wire [`SLP_NUM_CH-1:0] WORK_RX_SF_IN,
  input wire [`SLP_NUM_CH-1:0] WORK_RX_SD_IN,
  // receive side: protection section
  input wire [7:0] PROT_RX_DATA_IN,
  input wire PROT_RX_FS_IN,
  input wire PROT_RX_SF_IN,
  input wire PROT_RX_SD_IN,
  // receive side: normal and extra traffic outputs
  output reg [8*`SLP_NUM_CH-1:0] NORM_RX_DATA_OUT,
  output reg NORM_RX_FS_OUT,
  output reg [`SLP_NUM_CH-1:0] NORM_RX_SSF_OUT,
  output reg [7:0] EXTRA_RX_DATA_OUT,
  output reg EXTRA_RX_SSF_OUT,
  // protected trail state
  output reg TRAIL_FAIL_OUT
);
  // =====================================================
  // declarations
  localparam [31:0] SEC_LAST = SEC_CYCLES - 1;
  localparam [3:0] NCH = `SLP_NUM_CH;
  reg [11:0] ctrl_r; // switching type, extra enable, null choice, report
  reg [9:0] wtr_period_r; // wait_to_restore_period in seconds
  reg [2:0] cmd_r; // standing operator_command
  reg [3:0] cmd_ch_r; // channel named by the command
  reg [31:0] sec_cnt_r; // cycles within the current second
  reg [9:0] wtr_cnt_r; // seconds elapsed in wait_to_restore
  reg wtr_run_r; // wait_to_restore timing
  reg [3:0] act_ch_r; // channel carried on protection, 0 for none
  reg [3:0] act_req_r; // request code behind act_ch_r
  reg [7:0] test_r; // test pattern counter
  reg [8*`SLP_NUM_CH-1:0] work_rx_r; // working data aligned to sink stage
  reg work_fs_r;
  reg [`SLP_NUM_CH-1:0] work_sf_r;
  reg [7:0] prot_tx_r; // trail source stage
  reg prot_tx_fs_r;
  reg [7:0] tx_pos_r; // byte position on the transmit side
  reg fop_r; // protocol_failure_report
  reg [3:0] loc_req; // local request code
  reg [3:0] loc_ch; // local request channel
  reg [3:0] eff_req; // request after far-end comparison
  reg [3:0] eff_ch;
  reg [3:0] k1_req_tx; // request code signalled to far end
  reg [7:0] bridge_d; // selected protection transmit content
  reg [7:0] null_d;
  reg [31:0] rd_data;
  reg addr_ok;
  integer i;
  wire [7:0] prot_rx_d; // recovered protection data
  wire prot_rx_fs;
  wire [`SLP_APS_W-1:0] aps_rx; // accepted far-end signalling
  wire [3:0] far_req;
  wire [3:0] far_ch;
  wire [3:0] far_bridge;
  wire bidir;
  wire [`SLP_APS_W-1:0] aps_tx; // outgoing signalling
  wire [7:0] tx_pos_now;
  wire acc_done; // completing access phase
  wire wr_en;
  wire [3:0] wr_ch;
  wire [9:0] wr_wtr;
  wire sec_tick;

  assign far_req = aps_rx[12:9];
  assign far_ch = aps_rx[8:5];
  assign far_bridge = aps_rx[4:1];
  assign bidir = ctrl_r[`SLP_CTRL_BIDIR];
  // K1 = request and channel, K2 top bits = bridged channel and 1:n flag
  assign aps_tx = {k1_req_tx, eff_ch, act_ch_r, 1'b1};
  assign tx_pos_now = NORM_TX_FS_IN ? 8'h00 : tx_pos_r;
  assign acc_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_en = acc_done & PWRITE_IN & addr_ok;
  assign wr_ch = PWDATA_IN[`SLP_CMD_CH_LSB+3:`SLP_CMD_CH_LSB];
  assign wr_wtr = (PWDATA_IN[9:0] > `SLP_WTR_MAX) ? `SLP_WTR_MAX : PWDATA_IN[9:0];
  assign sec_tick = (sec_cnt_r == SEC_LAST);

  // =====================================================
  // signalling extraction, built for the protection section only
  slp_aps_extract u_aps (
    .clk_in(SYS_CLK_IN),
    .resetn_in(RESETN_IN),
    .d_in(PROT_RX_DATA_IN),
    .fs_in(PROT_RX_FS_IN),
    .d_out(prot_rx_d),
    .fs_out(prot_rx_fs),
    .aps_out(aps_rx)
  );

  // =====================================================
  // local request: priority resolution over commands and conditions
  always @* begin
    loc_req = `SLP_REQ_NR;
    loc_ch = 4'h0;
    if (cmd_r == `SLP_CMD_LOCKOUT) begin
      loc_req = `SLP_REQ_LO;
    end else if (PROT_RX_SF_IN) begin
      // a failed protection section can carry nothing
      loc_req = `SLP_REQ_NR;
    end else if (cmd_r == `SLP_CMD_FORCED) begin
      loc_req = `SLP_REQ_FS;
      loc_ch = cmd_ch_r;
    end else begin
      // lowest failed channel wins among equal requests
      for (i = `SLP_NUM_CH - 1; i >= 0; i = i - 1) begin
        if (WORK_RX_SF_IN[i]) begin
          loc_req = `SLP_REQ_SF;
          loc_ch = i[3:0] + 4'h1;
        end
      end
      if (loc_req == `SLP_REQ_NR) begin
        for (i = `SLP_NUM_CH - 1; i >= 0; i = i - 1) begin
          if (WORK_RX_SD_IN[i] && !PROT_RX_SD_IN) begin
            loc_req = `SLP_REQ_SD;
            loc_ch = i[3:0] + 4'h1;
          end
        end
      end
      if (loc_req == `SLP_REQ_NR) begin
        if (cmd_r == `SLP_CMD_MANUAL) begin
          loc_req = `SLP_REQ_MS;
          loc_ch = cmd_ch_r;
        end else if (wtr_run_r) begin
          loc_req = `SLP_REQ_WTR;
          loc_ch = act_ch_r;
        end else if (cmd_r == `SLP_CMD_EXERCISE_COMMAND) begin
          loc_req = `SLP_REQ_EXERCISE_COMMAND;
          loc_ch = cmd_ch_r;
        end
      end
    end
  end

  // =====================================================
  // far-end comparison, only in bidirectional switching
  always @* begin
    eff_req = loc_req;
    eff_ch = loc_ch;
    k1_req_tx = loc_req;
    if (bidir && loc_req != `SLP_REQ_LO && far_req > loc_req && far_req != `SLP_REQ_RR) begin
      eff_req = far_req;
      eff_ch = far_ch;
      k1_req_tx = `SLP_REQ_RR;
    end
  end

  // =====================================================
  // active channel follows the request at frame starts; the bridge takes that frame's first byte from the old selection;
  // exercise only signals and never moves traffic
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      act_ch_r <= 4'h0;
      act_req_r <= `SLP_REQ_NR;
    end else if (NORM_TX_FS_IN) begin
      if (eff_req == `SLP_REQ_NR || eff_req == `SLP_REQ_LO || eff_req == `SLP_REQ_EXERCISE_COMMAND) begin
        act_ch_r <= 4'h0;
        act_req_r <= eff_req;
      end else if (eff_ch != 4'h0 && eff_ch <= NCH) begin
        act_ch_r <= eff_ch;
        act_req_r <= eff_req;
      end
    end
  end

  // =====================================================
  // wait_to_restore: starts when a fail or degrade switch clears
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wtr_run_r <= 1'b0;
      wtr_cnt_r <= 10'h000;
      sec_cnt_r <= 32'h0000_0000;
    end else begin
      sec_cnt_r <= (sec_tick || !wtr_run_r) ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
      if (wr_en && PADDR_IN == `SLP_CMD_OFS && PWDATA_IN[2:0] == `SLP_CMD_CLEAR) begin
        wtr_run_r <= 1'b0;
      end else if (!wtr_run_r) begin
        wtr_cnt_r <= 10'h000;
        if (NORM_TX_FS_IN && act_ch_r != 4'h0 && loc_req == `SLP_REQ_NR &&
            (act_req_r == `SLP_REQ_SF || act_req_r == `SLP_REQ_SD)) begin
          wtr_run_r <= 1'b1;
        end
      end else if (loc_req > `SLP_REQ_WTR || wtr_cnt_r >= wtr_period_r) begin
        // pre-empted or expired; a period of zero reverts at once
        wtr_run_r <= 1'b0;
      end else if (sec_tick) begin
        wtr_cnt_r <= wtr_cnt_r + 10'h001;
      end
    end
  end

  // =====================================================
  // transmit: working outputs, bridge, trail source, signalling insertion
  always @* begin
    case (ctrl_r[`SLP_CTRL_NULL_LSB+1:`SLP_CTRL_NULL_LSB])
      `SLP_NULL_COPY: null_d = NORM_TX_DATA_IN[8*ctrl_r[9:8] +: 8];
      `SLP_NULL_ONES: null_d = 8'hff;
      `SLP_NULL_TEST: null_d = test_r;
      default: null_d = 8'hff;
    endcase
    if (act_ch_r != 4'h0) begin
      bridge_d = NORM_TX_DATA_IN[8*(act_ch_r-4'h1) +: 8];
    end else if (ctrl_r[`SLP_CTRL_EXTRA]) begin
      bridge_d = EXTRA_TX_DATA_IN;
    end else begin
      bridge_d = null_d;
    end
  end

  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WORK_TX_DATA_OUT <= {8*`SLP_NUM_CH{1'b0}};
      WORK_TX_FS_OUT <= 1'b0;
      prot_tx_r <= 8'h00;
      prot_tx_fs_r <= 1'b0;
      PROT_TX_DATA_OUT <= 8'h00;
      PROT_TX_FS_OUT <= 1'b0;
      tx_pos_r <= 8'h00;
      test_r <= 8'h00;
    end else begin
      // the working path is never switched and has one register stage, one less than the protection path
      WORK_TX_DATA_OUT <= NORM_TX_DATA_IN;
      WORK_TX_FS_OUT <= NORM_TX_FS_IN;
      prot_tx_r <= bridge_d;
      prot_tx_fs_r <= NORM_TX_FS_IN;
      PROT_TX_FS_OUT <= prot_tx_fs_r;
      tx_pos_r <= (tx_pos_now == 8'hff) ? 8'hff : tx_pos_now + 8'h01;
      test_r <= test_r + 8'h01;
      // tx_pos_r already counts the byte after prot_tx_r, hence the plus one
      if (tx_pos_r == `SLP_K1_POS + 8'h01) begin
        PROT_TX_DATA_OUT <= aps_tx[12:5];
      end else if (tx_pos_r == `SLP_K2_POS + 8'h01) begin
        PROT_TX_DATA_OUT <= {aps_tx[4:0], prot_tx_r[2:0]};
      end else begin
        PROT_TX_DATA_OUT <= prot_tx_r;
      end
    end
  end

  // =====================================================
  // receive: per-channel selector
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      work_rx_r <= {8*`SLP_NUM_CH{1'b0}};
      work_fs_r <= 1'b0;
      work_sf_r <= {`SLP_NUM_CH{1'b0}};
      NORM_RX_FS_OUT <= 1'b0;
    end else begin
      work_rx_r <= WORK_RX_DATA_IN;
      work_fs_r <= WORK_RX_FS_IN;
      work_sf_r <= WORK_RX_SF_IN;
      NORM_RX_FS_OUT <= work_fs_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SLP_NUM_CH; g = g + 1) begin : g_sel
      always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          NORM_RX_DATA_OUT[8*g +: 8] <= 8'h00;
          NORM_RX_SSF_OUT[g] <= 1'b0;
        end else if (act_ch_r == g + 1) begin
          NORM_RX_DATA_OUT[8*g +: 8] <= prot_rx_d;
          NORM_RX_SSF_OUT[g] <= PROT_RX_SF_IN;
        end else begin
          NORM_RX_DATA_OUT[8*g +: 8] <= work_rx_r[8*g +: 8];
          NORM_RX_SSF_OUT[g] <= work_sf_r[g];
        end
      end
    end
  endgenerate

  // =====================================================
  // extra traffic, trail sink and protocol check
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      EXTRA_RX_DATA_OUT <= 8'hff;
      EXTRA_RX_SSF_OUT <= 1'b0;
      TRAIL_FAIL_OUT <= 1'b0;
      fop_r <= 1'b0;
    end else begin
      if (act_ch_r != 4'h0) begin
        EXTRA_RX_DATA_OUT <= 8'hff;
        EXTRA_RX_SSF_OUT <= 1'b1;
      end else begin
        EXTRA_RX_DATA_OUT <= prot_rx_d;
        EXTRA_RX_SSF_OUT <= PROT_RX_SF_IN;
      end
      TRAIL_FAIL_OUT <= PROT_RX_SF_IN;
      // far end bridging another channel than the one act_ch_r selects here
      fop_r <= bidir && prot_rx_fs && act_ch_r != 4'h0 && far_bridge != act_ch_r;
    end
  end

  // =====================================================
  // apb register file; answers one cycle into the access phase
  always @* begin
    addr_ok = 1'b1;
    case (PADDR_IN)
      `SLP_CTRL_OFS: rd_data = {20'h00000, ctrl_r};
      `SLP_WTR_OFS: rd_data = {22'h000000, wtr_period_r};
      `SLP_CMD_OFS: rd_data = {24'h000000, cmd_ch_r, 1'b0, cmd_r};
      `SLP_STAT_OFS: rd_data = {3'h0, aps_rx, 4'h0, fop_r, TRAIL_FAIL_OUT,
                                TRAIL_FAIL_OUT & ctrl_r[`SLP_CTRL_REPORT],
                                wtr_run_r, act_req_r, act_ch_r};
      `SLP_APS_OFS: rd_data = {19'h00000, aps_tx};
      default: begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase
  end

  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~addr_ok;
      PRDATA_OUT <= (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN) ? rd_data : 32'h0000_0000;
    end
  end

  // configuration is only registers; with no request active act_ch_r stays 0
  // and only the idle protection transmit content, set by the extra and null fields, moves when they change
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_r <= `SLP_CTRL_RST;
      wtr_period_r <= `SLP_WTR_RST;
      cmd_r <= `SLP_CMD_NONE;
      cmd_ch_r <= 4'h0;
    end else if (wr_en) begin
      if (PADDR_IN == `SLP_CTRL_OFS) begin
        ctrl_r <= PWDATA_IN[11:0];
      end
      if (PADDR_IN == `SLP_WTR_OFS) begin
        wtr_period_r <= wr_wtr;
      end
      if (PADDR_IN == `SLP_CMD_OFS) begin
        if (PWDATA_IN[2:0] == `SLP_CMD_CLEAR) begin
          cmd_r <= `SLP_CMD_NONE;
          cmd_ch_r <= 4'h0;
        end else if (PWDATA_IN[2:0] == `SLP_CMD_LOCKOUT) begin
          cmd_r <= `SLP_CMD_LOCKOUT;
          cmd_ch_r <= 4'h0;
        end else if (PWDATA_IN[2:0] >= `SLP_CMD_FORCED && PWDATA_IN[2:0] <= `SLP_CMD_EXERCISE_COMMAND &&
                     wr_ch != 4'h0 && wr_ch <= NCH) begin
          cmd_r <= PWDATA_IN[2:0];
          cmd_ch_r <= wr_ch;
        end
      end
    end
  end
endmodule

// [dv/slp_one_to_n_protection_properties.sv]
`timescale 1ns/100ps
// ========================================
// port properties of the protection block
module slp_props (
  // clock, reset, apb handshake
  input wire SYS_CLK_IN, RESETN_IN, PSEL_IN, PENABLE_IN, PREADY_OUT, PSLVERR_OUT,
  // stream ports
  input wire [31:0] NORM_TX_DATA_IN, WORK_TX_DATA_OUT,
  input wire NORM_TX_FS_IN, PROT_TX_FS_OUT, WORK_RX_FS_IN, NORM_RX_FS_OUT, PROT_RX_SF_IN, TRAIL_FAIL_OUT,
  input wire [7:0] EXTRA_RX_DATA_OUT,
  input wire EXTRA_RX_SSF_OUT
);
  // edges since release, so $past in the checks guarded by up_r never reaches into reset
  reg [1:0] up_r;
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  work_tx_a: assert property (up_r != 2'h0 |-> WORK_TX_DATA_OUT == $past(NORM_TX_DATA_IN))
    else $error("working data wrong");
  prot_frame_a: assert property (up_r[1] |-> PROT_TX_FS_OUT == $past(NORM_TX_FS_IN, 2))
    else $error("protection frame start wrong");
  rx_frame_a: assert property (up_r[1] |-> NORM_RX_FS_OUT == $past(WORK_RX_FS_IN, 2))
    else $error("receive frame start wrong");
  trail_fail_a: assert property (up_r != 2'h0 |-> TRAIL_FAIL_OUT == $past(PROT_RX_SF_IN))
    else $error("trail fail wrong");
  extra_ais_a: assert property (EXTRA_RX_SSF_OUT && !$past(PROT_RX_SF_IN) |-> EXTRA_RX_DATA_OUT == 8'hff)
    else $error("extra output not all ones");
  switch_frame_a: assert property ($rose(EXTRA_RX_SSF_OUT) && !$past(PROT_RX_SF_IN) |->
    $past(NORM_TX_FS_IN) || $past(NORM_TX_FS_IN, 2))
    else $error("switch away from frame start");
  apb_answer_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("apb answer timing wrong");
  apb_error_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
endmodule

// [dv/slp_far_end.sv]
`timescale 1ns/100ps
// ========================================
// far-end sections: framed bytes, switching bytes on protection
module slp_far_end #(
  parameter FRAME_LEN = 8
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // value to signal; flip alternates its lsb each frame
  input wire [12:0] aps_in,
  input wire flip_in,
  // section streams
  output reg fs_out,
  output reg [31:0] work_out,
  output reg [7:0] prot_out
);
  integer pos;
  reg odd_r;
  wire [12:0] aps_w = aps_in ^ {12'h0, flip_in & odd_r};
  // payload changes every byte, so a stale value never looks right
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {pos, odd_r, fs_out, work_out, prot_out} <= 0;
    end else begin
      pos <= (pos + 1) % FRAME_LEN;
      fs_out <= pos == 0;
      work_out <= $urandom;
      odd_r <= odd_r ^ (pos == 0);
      if (pos == 1) begin
        prot_out <= aps_w[12:5];
      end else if (pos == 2) begin
        prot_out <= {aps_w[4:0], 3'($urandom)};
      end else begin
        prot_out <= 8'($urandom);
      end
    end
  end
endmodule

// [dv/slp_one_to_n_protection_bench.sv]
`timescale 1ns/100ps
`include "slp_regs.vh"
// ========================================
// bench: cycle model of both paths, apb register checks
module slp_one_to_n_protection_bench;
  reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, psf = 1'b0, flip = 1'b0, chk = 1'b0, e;
  reg s1 = 1'b0; // protection fail as the design sampled it one edge ago
  reg [7:0] padr = 8'h0, etx = 8'h0, p1, p2, e1, e2;
  reg [31:0] pwd = 32'h0, ntx = 32'h0, rd, n1, n2, w1, w2;
  reg [3:0] sf = 4'h0, sd = 4'h0;
  reg [12:0] aps = 13'h0, v;
  wire [31:0] prd, nrx, wrx;
  wire [7:0] ptx, prx, erx;
  wire [3:0] nssf;
  wire rdy, err, fs, pfs, essf;
  integer failures = 0, checks = 0, sw = 0, pt = 0, opos = 0, i, k;
  // command steps: code, channel, channel then carried by protection
  int cmd_t[6] = '{2, 1, 4, 3, 5, 4};
  int ch_t[6] = '{2, 1, 1, 4, 1, 1};
  int sw_t[6] = '{2, 0, 0, 4, 0, 0};
  // control words and what the idle protection output carries (4 ones, 5 extra)
  int ctl_t[4] = '{12'h014, 12'h012, 12'h210, 12'h010};
  int pt_t[4] = '{4, 5, 2, 0};
  initial begin
    forever #12.5 clk = ~clk;
  end
  // short second so a wait period stays a few cycles
  slp_one_to_n_protection #(.SEC_CYCLES(10)) dut_u (
    .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
    .NORM_TX_DATA_IN(ntx), .NORM_TX_FS_IN(fs), .EXTRA_TX_DATA_IN(etx), .WORK_TX_DATA_OUT(),
    .WORK_TX_FS_OUT(), .PROT_TX_DATA_OUT(ptx), .PROT_TX_FS_OUT(pfs), .WORK_RX_DATA_IN(wrx),
    .WORK_RX_FS_IN(fs), .WORK_RX_SF_IN(sf), .WORK_RX_SD_IN(sd), .PROT_RX_DATA_IN(prx),
    .PROT_RX_FS_IN(fs), .PROT_RX_SF_IN(psf), .PROT_RX_SD_IN(1'b0), .NORM_RX_DATA_OUT(nrx),
    .NORM_RX_FS_OUT(), .NORM_RX_SSF_OUT(nssf), .EXTRA_RX_DATA_OUT(erx), .EXTRA_RX_SSF_OUT(essf),
    .TRAIL_FAIL_OUT());
  slp_far_end far_u (.clk_in(clk), .resetn_in(rst_n), .aps_in(aps), .flip_in(flip), .fs_out(fs),
    .work_out(wrx), .prot_out(prx));
  task automatic cmp(input string nm, input [31:0] ex, got);
    checks = checks + 1;
    if (got !== ex) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // apb master: request held until ready is sampled, bounded wait
  task automatic apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge clk);
    end
    if (n == 20) begin
      failures = failures + 1;
      stop_test;
    end else begin
      {rd, e} = {prd, err};
      {psel, pen} <= 2'b00;
    end
  endtask
  // model: selection and protection output, two cycles deep; skips signalling bytes
  always @(posedge clk) begin
    opos = pfs ? 0 : opos + 1;
    if (chk && opos > 2) begin
      for (k = 0; k < 4; k = k + 1) begin
        cmp("rx normal", k + 1 == sw ? p2 : w2[8*k+:8], nrx[8*k+:8]);
        cmp("rx fail", k + 1 == sw ? psf : sf[k], nssf[k]);
      end
      // unswitched, the extra output relays the protection section's fail
      cmp("extra fail", sw != 0 || s1, essf);
      cmp("extra rx", sw != 0 ? 8'hff : p2, erx);
      if (pt < 6) begin
        cmp("prot out", pt == 4 ? 8'hff : pt == 5 ? e2 : n2[8*pt+:8], ptx);
      end
    end
    // second signalling byte names the bridged channel and the 1:n flag
    if (chk && opos == 2) begin
      cmp("tx bridged", {sw[3:0], 1'b1}, ptx[7:3]);
    end
    s1 = psf;
    {w2, w1, n2, n1} = {w1, wrx, n1, ntx};
    {p2, p1, e2, e1} = {p1, prx, e1, etx};
    ntx <= $urandom;
    etx <= 8'($urandom);
  end
  initial begin
    void'($urandom(35223));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, `SLP_CTRL_OFS, 0);
    cmp("ctrl", 32'h010, rd);
    apb(0, `SLP_WTR_OFS, 0);
    cmp("wtr", 32'h12c, rd);
    apb(1, 8'h14, 32'hffff);
    apb(0, 8'h14, 0);
    cmp("unmapped", 32'h1, {rd[30:0], e});
    // idle changes of wait period, switching type, protection fail and idle protection content, traffic watched
    chk <= 1'b1;
    apb(1, `SLP_WTR_OFS, 800);
    apb(0, `SLP_WTR_OFS, 0);
    cmp("wtr clamp", 720, rd);
    apb(1, `SLP_WTR_OFS, 0);
    apb(1, `SLP_CTRL_OFS, 32'h011);
    psf <= 1'b1;
    apb(1, `SLP_CTRL_OFS, 32'h010);
    psf <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      pt <= 6;
      apb(1, `SLP_CTRL_OFS, ctl_t[i]);
      repeat (12) @(posedge clk);
      pt <= pt_t[i];
      repeat (24) @(posedge clk);
    end
    for (i = 0; i < 8; i = i + 1) begin
      chk <= 1'b0;
      if (i < 6) begin
        apb(1, `SLP_CMD_OFS, ch_t[i] * 16 + cmd_t[i]);
      end else begin
        sf <= i == 6 ? 4'h4 : 4'h0;
        sd <= i == 6 ? 4'h1 : 4'h0;
      end
      repeat (24) @(posedge clk);
      sw <= i < 6 ? sw_t[i] : i == 6 ? 3 : 0;
      pt <= i < 6 ? (sw_t[i] != 0 ? sw_t[i] - 1 : 0) : i == 6 ? 2 : 0;
      chk <= 1'b1;
      repeat (24) @(posedge clk);
    end
    // far signalling: adopted, ignored while unsteady, then replaced
    v = 13'($urandom);
    for (i = 0; i < 3; i = i + 1) begin
      aps <= i == 0 ? v : v ^ 13'h0ff0;
      flip <= i == 1;
      repeat (64) @(posedge clk);
      apb(0, `SLP_STAT_OFS, 0);
      cmp("rx signalling", i == 2 ? v ^ 13'h0ff0 : v, rd[28:16]);
    end
    stop_test;
  end
endmodule
bind slp_one_to_n_protection slp_props props_u (.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .NORM_TX_DATA_IN(NORM_TX_DATA_IN), .WORK_TX_DATA_OUT(WORK_TX_DATA_OUT), .NORM_TX_FS_IN(NORM_TX_FS_IN),
  .PROT_TX_FS_OUT(PROT_TX_FS_OUT), .WORK_RX_FS_IN(WORK_RX_FS_IN), .NORM_RX_FS_OUT(NORM_RX_FS_OUT),
  .PROT_RX_SF_IN(PROT_RX_SF_IN), .TRAIL_FAIL_OUT(TRAIL_FAIL_OUT), .EXTRA_RX_DATA_OUT(EXTRA_RX_DATA_OUT),
  .EXTRA_RX_SSF_OUT(EXTRA_RX_SSF_OUT));
